//--- pkg/plg_pkg.sv
// plg_pkg: constants and types for the indicator and multi-function pin block
// assumes a single 50 MHz clock and synchronous status inputs from the phy core
package plg_pkg;

  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned BLINK_PERIOD_MS = 100;
  // half period of the activity blink in clock cycles
  localparam int unsigned BLINK_HALF_CYC  = (CLK_HZ / 1000) * BLINK_PERIOD_MS / 2;
  localparam int unsigned BLINK_W         = 22;
  localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_HALF_CYC - 1);
  localparam logic [BLINK_W-1:0] BLINK_ZERO = 22'h000000;

  // mac interface modes
  typedef enum logic [1:0] {
    PLG_MAC_MII   = 2'h0,
    PLG_MAC_RMII  = 2'h1,
    PLG_MAC_RGMII = 2'h2
  } plg_mac_e;

  // link indicator modes
  typedef enum logic {
    PLG_LINK_ONLY = 1'h0,
    PLG_LINK_ACT  = 1'h1
  } plg_link_mode_e;

  // speed pin functions
  typedef enum logic [1:0] {
    PLG_SPD_TRISTATE = 2'h0,
    PLG_SPD_SPEED    = 2'h1,
    PLG_SPD_SIGDET   = 2'h2,
    PLG_SPD_GPIO     = 2'h3
  } plg_spd_fn_e;

  // collision and rx data bit three pin functions
  typedef enum logic [1:0] {
    PLG_PIN_NATIVE = 2'h0,
    PLG_PIN_LED    = 2'h1,
    PLG_PIN_GPIO   = 2'h2
  } plg_pin_fn_e;

  // media signalling
  typedef enum logic [1:0] {
    PLG_MED_AUTO = 2'h0,
    PLG_MED_10TE = 2'h1,
    PLG_MED_100TX = 2'h2,
    PLG_MED_100FX = 2'h3
  } plg_media_e;

endpackage : plg_pkg

//--- design/plg_blink.sv
// plg_blink: toggle used for the activity blink, runs only while run is high and clears otherwise
// assumes clk is the reference-derived 50 MHz clock
`timescale 1ns/100ps
`default_nettype none
module plg_blink (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      phase
);

  typedef struct packed {
    logic [plg_pkg::BLINK_W-1:0] cnt;
    logic                        ph;
  } plg_blink_s;

  plg_blink_s st;
  plg_blink_s next_st;

  always_comb begin
    next_st = st;
    if (!run) begin
      // restart so the blink starts with a visible on phase (ph low keeps the led lit)
      next_st.cnt = plg_pkg::BLINK_ZERO;
      next_st.ph  = 1'b0;
    end else if (st.cnt == plg_pkg::BLINK_LAST) begin
      next_st.cnt = plg_pkg::BLINK_ZERO;
      next_st.ph  = ~st.ph;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign phase = st.ph;

endmodule : plg_blink
`default_nettype wire

//--- design/plg_pins.sv
// plg_pins: led, gpio and multi-function pin logic of a 10/100 phy
// assumes status inputs synchronous to clk; pad resolves the o/oe pairs
// Summary of operation
// - default mode: link led follows link
// - activity mode: steady on, blinks on activity
// - speed pin undriven in default mode
// - speed mode: on at 100, off at 10
// - fiber mode: speed pin is signal detect input
// - speed pin usable as general io one
// - mii full duplex: collision pin may drive led
// - rmii/rgmii: collision pin led or general io two
// - rx data bit three: led/io three in rmii
// - media pairs auto or forced signalling mode
// - collision low full duplex, tx and rx half
`timescale 1ns/100ps
`default_nettype none
module plg_pins (
  input  wire logic                   clk,
  input  wire logic                   rst,
  // phy core status
  input  wire logic                   link_up,
  input  wire logic                   speed_100,
  input  wire logic                   full_duplex,
  input  wire logic                   tx_active,
  input  wire logic                   rx_active,
  input  wire logic                   rx_data3_core,
  input  wire logic [1:0]             media_detected,
  // configuration
  input  wire logic [1:0]             mac_mode,
  input  wire logic                   link_mode,
  input  wire logic [1:0]             speed_pin_fn,
  input  wire logic [1:0]             col_pin_fn,
  input  wire logic [1:0]             rxd3_pin_fn,
  input  wire logic [1:0]             media_force,
  input  wire logic                   aux_led_src,
  input  wire logic [2:0]             gpio_out,
  input  wire logic [2:0]             gpio_oe,
  // pins
  output logic                        link_activity_indicator,
  input  wire logic                   speed_indicator_pin_i,
  output logic                        speed_indicator_pin_o,
  output logic                        speed_indicator_pin_oe,
  input  wire logic                   col_pin_i,
  output logic                        col_pin_o,
  output logic                        col_pin_oe,
  input  wire logic                   rx_data3_pin_i,
  output logic                        rx_data3_pin_o,
  output logic                        rx_data3_pin_oe,
  // status back to core
  output logic                        fiber_signal_detect,
  output logic [2:0]                  gpio_in,
  output logic [1:0]                  media_mode
);

  typedef struct packed {
    logic       led0;
    logic       spd_o;
    logic       spd_oe;
    logic       col_o;
    logic       col_oe;
    logic       rxd3_o;
    logic       rxd3_oe;
    logic       sigdet;
    logic [2:0] gin;
    logic [1:0] media;
  } plg_pins_s;

  plg_pins_s st;
  plg_pins_s next_st;
  logic      blink_ph;
  logic      activity;

  // activity only counts while the link is good
  assign activity = link_up && (tx_active || rx_active);

  plg_blink plg_blink_inst (
    .clk   (clk),
    .rst   (rst),
    .run   (activity),
    .phase (blink_ph)
  );

  // drive of one multi-function pin: level and output enable
  typedef struct packed {
    logic o;
    logic oe;
  } plg_drive_s;

  // link led: plain link, or link with the activity blink
  function automatic logic led0_level(
    input logic mode,
    input logic lnk,
    input logic act,
    input logic ph
  );
    if (plg_pkg::plg_link_mode_e'(mode) == plg_pkg::PLG_LINK_ACT) begin
      led0_level = lnk && !(act && ph);
    end else begin
      led0_level = lnk;
    end
  endfunction : led0_level

  // shared led decode for the reconfigured collision and rx data pins
  function automatic logic aux_led(
    input logic src,
    input logic lnk,
    input logic spd
  );
    if (src) begin
      aux_led = lnk && spd;
    end else begin
      aux_led = lnk;
    end
  endfunction : aux_led

  // collision per duplex state
  function automatic logic coll(
    input logic fd,
    input logic tx,
    input logic rx
  );
    if (fd) begin
      coll = 1'b0;
    end else begin
      coll = tx && rx;
    end
  endfunction : coll

  // pin function decode shared by the collision and rx data pins
  function automatic logic fn_is_led(
    input logic [1:0] fn
  );
    fn_is_led = plg_pkg::plg_pin_fn_e'(fn) == plg_pkg::PLG_PIN_LED;
  endfunction : fn_is_led

  function automatic logic fn_is_gpio(
    input logic [1:0] fn
  );
    fn_is_gpio = plg_pkg::plg_pin_fn_e'(fn) == plg_pkg::PLG_PIN_GPIO;
  endfunction : fn_is_gpio

  // led only where collision carries no meaning
  function automatic logic col_led_ok(
    input logic [1:0] mac,
    input logic       fd
  );
    unique case (plg_pkg::plg_mac_e'(mac))
      plg_pkg::PLG_MAC_MII: begin
        col_led_ok = fd;
      end
      plg_pkg::PLG_MAC_RMII, plg_pkg::PLG_MAC_RGMII: begin
        col_led_ok = 1'b1;
      end
      default: begin
        col_led_ok = 1'b0;
      end
    endcase
  endfunction : col_led_ok

  function automatic logic col_gpio_ok(
    input logic [1:0] mac
  );
    col_gpio_ok = plg_pkg::plg_mac_e'(mac) == plg_pkg::PLG_MAC_RMII
                  || plg_pkg::plg_mac_e'(mac) == plg_pkg::PLG_MAC_RGMII;
  endfunction : col_gpio_ok

  // rx data bit three carries data in mii and rgmii, so only rmii frees it
  function automatic logic rxd3_free(
    input logic [1:0] mac
  );
    rxd3_free = plg_pkg::plg_mac_e'(mac) == plg_pkg::PLG_MAC_RMII;
  endfunction : rxd3_free

  // speed pin: undriven, speed led, detect input or general io one
  function automatic plg_drive_s spd_drive(
    input logic [1:0] fn,
    input logic       lnk,
    input logic       s100,
    input logic       gpo,
    input logic       gpoe
  );
    plg_drive_s d;
    d.o  = 1'b0;
    d.oe = 1'b0;
    unique case (plg_pkg::plg_spd_fn_e'(fn))
      plg_pkg::PLG_SPD_TRISTATE: begin
        d.oe = 1'b0;
      end
      plg_pkg::PLG_SPD_SPEED: begin
        d.o  = lnk && s100;
        d.oe = 1'b1;
      end
      plg_pkg::PLG_SPD_SIGDET: begin
        d.oe = 1'b0;
      end
      plg_pkg::PLG_SPD_GPIO: begin
        d.o  = gpo;
        d.oe = gpoe;
      end
    endcase
    spd_drive = d;
  endfunction : spd_drive

  // collision pin: native collision, led or general io two
  function automatic plg_drive_s col_drive(
    input logic [1:0] mac,
    input logic [1:0] fn,
    input logic       fd,
    input logic       led,
    input logic       col,
    input logic       gpo,
    input logic       gpoe
  );
    plg_drive_s d;
    d.o  = col;
    d.oe = 1'b1;
    if (fn_is_led(fn) && col_led_ok(mac, fd)) begin
      d.o = led;
    end else if (fn_is_gpio(fn) && col_gpio_ok(mac)) begin
      d.o  = gpo;
      d.oe = gpoe;
    end
    col_drive = d;
  endfunction : col_drive

  // rx data bit three: core data, led or general io three
  function automatic plg_drive_s rxd3_drive(
    input logic [1:0] mac,
    input logic [1:0] fn,
    input logic       led,
    input logic       dat,
    input logic       gpo,
    input logic       gpoe
  );
    plg_drive_s d;
    d.o  = dat;
    d.oe = 1'b1;
    if (fn_is_led(fn) && rxd3_free(mac)) begin
      d.o = led;
    end else if (fn_is_gpio(fn) && rxd3_free(mac)) begin
      d.o  = gpo;
      d.oe = gpoe;
    end
    rxd3_drive = d;
  endfunction : rxd3_drive

  // forced signalling wins, otherwise what autodetect found
  function automatic logic [1:0] media_sel(
    input logic [1:0] force_mode,
    input logic [1:0] found
  );
    if (plg_pkg::plg_media_e'(force_mode) == plg_pkg::PLG_MED_AUTO) begin
      media_sel = found;
    end else begin
      media_sel = force_mode;
    end
  endfunction : media_sel

  plg_drive_s spd_drv;
  plg_drive_s col_drv;
  plg_drive_s rxd3_drv;

  assign spd_drv  = spd_drive(speed_pin_fn, link_up, speed_100, gpio_out[0], gpio_oe[0]);
  assign col_drv  = col_drive(mac_mode, col_pin_fn, full_duplex, aux_led(aux_led_src, link_up, speed_100),
                              coll(full_duplex, tx_active, rx_active), gpio_out[1], gpio_oe[1]);
  assign rxd3_drv = rxd3_drive(mac_mode, rxd3_pin_fn, aux_led(aux_led_src, link_up, speed_100),
                               rx_data3_core, gpio_out[2], gpio_oe[2]);

  always_comb begin
    next_st = st;

    // link indicator
    next_st.led0 = led0_level(link_mode, link_up, activity, blink_ph);

    // speed pin
    next_st.spd_o  = spd_drv.o;
    next_st.spd_oe = spd_drv.oe;
    next_st.sigdet = 1'b0;
    if (plg_pkg::plg_spd_fn_e'(speed_pin_fn) == plg_pkg::PLG_SPD_SIGDET) begin
      next_st.sigdet = speed_indicator_pin_i;
    end

    // collision pin
    next_st.col_o  = col_drv.o;
    next_st.col_oe = col_drv.oe;

    // rx data bit three
    next_st.rxd3_o  = rxd3_drv.o;
    next_st.rxd3_oe = rxd3_drv.oe;

    // gpio readback always reflects the pads
    next_st.gin = {rx_data3_pin_i, col_pin_i, speed_indicator_pin_i};

    // media: forced mode wins, otherwise what autodetect found
    next_st.media = media_sel(media_force, media_detected);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link_activity_indicator = st.led0;
  assign speed_indicator_pin_o   = st.spd_o;
  assign speed_indicator_pin_oe  = st.spd_oe;
  assign col_pin_o               = st.col_o;
  assign col_pin_oe              = st.col_oe;
  assign rx_data3_pin_o          = st.rxd3_o;
  assign rx_data3_pin_oe         = st.rxd3_oe;
  assign fiber_signal_detect     = st.sigdet;
  assign gpio_in                 = st.gin;
  assign media_mode              = st.media;

endmodule : plg_pins
`default_nettype wire

//--- tb/plg_pad_model.sv
// plg_pad_model: far side of one multi-function pin
// assumes o/oe from the pin block; the pull sets the level when nobody drives
`timescale 1ns/100ps
`default_nettype none
module plg_pad_model #(
  parameter logic PULL = 1'h0
) (
  input  wire logic oe,
  input  wire logic o,
  input  wire logic ext_en,
  input  wire logic ext_v,
  output logic      pad
);
  // transceiver drives detect at full io level, only while the pin listens
  assign pad = oe ? o : (ext_en ? ext_v : PULL);
endmodule : plg_pad_model
`default_nettype wire

//--- tb/plg_pins_checker.sv
// plg_pins_checker: port-level properties of the pin block
// assumes one clock, sync active-high reset, outputs one cycle behind inputs
`timescale 1ns/100ps
`default_nettype none
module plg_pins_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       link_up,
  input wire logic       speed_100,
  input wire logic       full_duplex,
  input wire logic       tx_active,
  input wire logic       rx_active,
  input wire logic       rx_data3_core,
  input wire logic [1:0] mac_mode,
  input wire logic       link_mode,
  input wire logic [1:0] speed_pin_fn,
  input wire logic [1:0] col_pin_fn,
  input wire logic [2:0] gpio_out,
  input wire logic [2:0] gpio_oe,
  input wire logic       link_activity_indicator,
  input wire logic       speed_indicator_pin_i,
  input wire logic       speed_indicator_pin_o,
  input wire logic       speed_indicator_pin_oe,
  input wire logic       col_pin_o,
  input wire logic       rx_data3_pin_o,
  input wire logic       fiber_signal_detect
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_link_follow: assert property (!link_mode |=> link_activity_indicator == $past(link_up))
    else $error("link led not following link");
  chk_act_steady: assert property (link_mode && link_up && !tx_active && !rx_active |=> link_activity_indicator)
    else $error("activity led not steady on");
  chk_spd_hiz: assert property (speed_pin_fn == 2'h0 |=> !speed_indicator_pin_oe)
    else $error("speed pin driven in default mode");
  chk_spd_led: assert property (speed_pin_fn == 2'h1 |=> speed_indicator_pin_oe
    && speed_indicator_pin_o == $past(link_up && speed_100))
    else $error("speed led wrong");
  chk_sig_det: assert property (speed_pin_fn == 2'h2 |=> !speed_indicator_pin_oe
    && fiber_signal_detect == $past(speed_indicator_pin_i))
    else $error("signal detect wrong");
  chk_gpio_one: assert property (speed_pin_fn == 2'h3 |=> speed_indicator_pin_o == $past(gpio_out[0])
    && speed_indicator_pin_oe == $past(gpio_oe[0]))
    else $error("general io one wrong");
  chk_rxd3_keep: assert property (mac_mode == 2'h0 || mac_mode == 2'h2 |=> rx_data3_pin_o == $past(rx_data3_core))
    else $error("rx data bit three lost");
  chk_col_fdx: assert property (col_pin_fn == 2'h0 && full_duplex |=> !col_pin_o)
    else $error("collision high in full duplex");
  chk_col_mii_hdx: assert property (mac_mode == 2'h0 && !full_duplex
    |=> col_pin_o == $past(tx_active && rx_active))
    else $error("collision pin reconfigured in mii half duplex");
endmodule : plg_pins_checker
bind plg_pins plg_pins_checker plg_pins_checker_inst (.*);
`default_nettype wire

//--- tb/plg_pins_tb.sv
// plg_pins_tb: table and directed checks of the pin block
// assumes pad models and checker from tb/
`timescale 1ns/100ps
`default_nettype none
module plg_pins_tb;
  logic clk = 1'h0, rst = 1'h1, link_up = 1'h1, speed_100 = 1'h0, full_duplex = 1'h0;
  logic tx_active = 1'h0, rx_active = 1'h0, rx_data3_core = 1'h0, link_mode = 1'h0, aux_led_src = 1'h0;
  logic sd_en = 1'h0, sd_level = 1'h0, far_en = 1'h0, far_v = 1'h0;
  logic [1:0] media_detected = 2'h2, mac_mode = 2'h0, speed_pin_fn = 2'h0, col_pin_fn = 2'h0;
  logic [1:0] rxd3_pin_fn = 2'h0, media_force = 2'h0, media_mode;
  logic [2:0] gpio_out = 3'h0, gpio_oe = 3'h7, gpio_in;
  logic link_activity_indicator, speed_indicator_pin_i, speed_indicator_pin_o, speed_indicator_pin_oe;
  logic col_pin_i, col_pin_o, col_pin_oe, rx_data3_pin_i, rx_data3_pin_o, rx_data3_pin_oe, fiber_signal_detect;
  int err_count = 0, n_checks = 0;
  // row: mac, fdx, col fn, rxd3 fn, aux, s100, gpio out | exp col, exp rxd3
  logic [13:0] rows [7] = '{14'h0a82, 14'h0200, 14'h12e3, 14'h12c0, 14'h251a, 14'h1d31, 14'h2202};

  plg_pins plg_pins_inst (.*);
  plg_pad_model #(.PULL(1'h0)) spd_model (.oe(speed_indicator_pin_oe), .o(speed_indicator_pin_o),
    .ext_en(sd_en), .ext_v(sd_level), .pad(speed_indicator_pin_i));
  plg_pad_model #(.PULL(1'h1)) col_model (.oe(col_pin_oe), .o(col_pin_o),
    .ext_en(far_en), .ext_v(far_v), .pad(col_pin_i));
  plg_pad_model #(.PULL(1'h0)) rxd3_model (.oe(rx_data3_pin_oe), .o(rx_data3_pin_o),
    .ext_en(far_en), .ext_v(far_v), .pad(rx_data3_pin_i));

  always #10 clk = ~clk;

  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic test_done;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // about 50 cycles of tests; thirty times that is a hang
  initial begin
    #30000;
    err_count++;
    test_done();
  end

  initial begin
    repeat (6) @(negedge clk);
    cmp(link_activity_indicator, 4'h0);
    rst = 1'h0;
    foreach (rows[i]) begin
      {mac_mode, full_duplex, col_pin_fn, rxd3_pin_fn, aux_led_src, speed_100, gpio_out} = rows[i][13:2];
      speed_pin_fn = 2'(i);
      link_mode = i[0];
      @(negedge clk);
      cmp(col_pin_o, rows[i][1]);
      cmp(rx_data3_pin_o, rows[i][0]);
    end
    for (int m = 0; m < 4; m++) begin
      media_force = 2'(m);
      media_detected = 2'(m + 1);
      @(negedge clk);
      cmp(media_mode, (m == 0) ? media_detected : 2'(m));
    end
    speed_pin_fn = 2'h2;
    sd_en = 1'h1;
    for (int v = 1; v >= 0; v--) begin
      sd_level = v[0];
      repeat (2) @(negedge clk);
      cmp(fiber_signal_detect, v[0]);
      cmp(gpio_in[0], v[0]);
    end
    sd_en = 1'h0;
    // listening gpio pins read back what the far side drives
    {mac_mode, col_pin_fn, rxd3_pin_fn, gpio_oe, far_en} = {2'h1, 2'h2, 2'h2, 3'h0, 1'h1};
    for (int v = 1; v >= 0; v--) begin
      far_v = v[0];
      repeat (2) @(negedge clk);
      cmp(col_pin_oe, 4'h0);
      cmp(rx_data3_pin_oe, 4'h0);
      cmp(gpio_in[2:1], {2{v[0]}});
    end
    {gpio_oe, far_en} = {3'h7, 1'h0};
    // activity shorter than half a blink period keeps the led lit
    {link_mode, tx_active, rx_active, full_duplex, col_pin_fn, mac_mode} = {4'hf, 4'h0};
    repeat (20) @(negedge clk);
    cmp(link_activity_indicator, 4'h1);
    cmp(col_pin_o, 4'h0);
    {full_duplex, rx_data3_core} = 2'h1;
    @(negedge clk);
    cmp(col_pin_o, 4'h1);
    cmp(rx_data3_pin_o, 4'h1);
    {tx_active, rx_active, link_up} = 3'h0;
    @(negedge clk);
    cmp(link_activity_indicator, 4'h0);
    link_up = 1'h1;
    rst = 1'h1;
    repeat (2) @(negedge clk);
    cmp(link_activity_indicator, 4'h0);
    rst = 1'h0;
    @(negedge clk);
    cmp(link_activity_indicator, 4'h1);
    test_done();
  end
endmodule : plg_pins_tb
`default_nettype wire
